/* sem_core.sv */
`timescale 1ns/1ps
module sem_core import sem_pkg::*; #(
    parameter int         ADDR_W       = ADDR_W_DEF,
    parameter int         PAGE_BYTES   = PAGE_BYTES_DEF,
    parameter int         WRITE_CYCLES = WRITE_CYCLES_DEF,
    parameter logic [1:0] PROTECT_INIT = PROTECT_NONE,
    parameter logic       PIN_EN_INIT  = 1'b0
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic csN,
    input  wire logic sck,
    input  wire logic si,
    output logic      so,
    output logic      soOe
);

    localparam int DEPTH = 1 << ADDR_W;
    localparam int OFF_W = $clog2(PAGE_BYTES);
    localparam int SEL_W = ADDR_W - OFF_W;
    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

    initial begin
        if (ADDR_W < 2 || ADDR_W > 8 * ADDR_BYTES)
            $error("sem_core: ADDR_W out of range");
        if (PAGE_BYTES < 2 || (1 << OFF_W) != PAGE_BYTES || OFF_W >= ADDR_W)
            $error("sem_core: PAGE_BYTES must be a power of two below the array size");
        if (WRITE_CYCLES < 1)
            $error("sem_core: WRITE_CYCLES must be positive");
    end

    // Is the addressed page inside the block range flagged by the protect bits
    function automatic logic isProtected(input logic [ADDR_W-1:0] addr,
                                         input logic [1:0]        bp);
        logic [1:0] top;
        top = addr[ADDR_W-1 -: 2];
        unique case (bp)
            PROTECT_NONE:    isProtected = 1'b0;
            PROTECT_QUARTER: isProtected = (top == 2'h3);
            PROTECT_HALF:    isProtected = top[1];
            default:         isProtected = 1'b1;
        endcase
    endfunction

    logic [2:0]              csSync_reg;
    logic [2:0]              sckSync_reg;
    logic [2:0]              siSync_reg;
    sem_link_s               link;

    sem_state_e              state_reg;
    logic [2:0]              bitCnt_reg;
    logic [6:0]              inShift_reg;
    logic [7:0]              rxByte;
    logic                    byteDone;
    logic                    isWrite_reg;
    logic                    latchSet_reg;
    logic                    addrCnt_reg;
    logic [7:0]              addrHi_reg;
    logic [ADDR_W-1:0]       addrFull;

    logic [7:0]              mem_reg [DEPTH];
    logic [7:0]              pageBuf_reg [PAGE_BYTES];
    logic [PAGE_BYTES-1:0]   pageMask_reg;
    logic [OFF_W-1:0]        pageOff_reg;
    logic [SEL_W-1:0]        pageSel_reg;
    logic                    gotData_reg;

    logic                    latch_reg;
    logic                    busy_reg;
    logic [CNT_W-1:0]        busyCnt_reg;
    logic                    busyDone;
    logic                    writeGo;
    logic [1:0]              protect_reg;
    logic                    pinEnable_reg;
    sem_status_s             status;

    logic [ADDR_W-1:0]       readPtr_reg;
    logic                    fetchValid;
    logic                    fetchReady;
    logic                    popValid;
    logic [7:0]              popData;
    logic                    popReady;
    logic [2:0]              outCnt_reg;
    logic [6:0]              outShift_reg;
    logic [7:0]              loadByte;
    logic                    outLoad;

    // Three-stage capture of every pin; edges judged on stages two and three
    always_ff @(posedge clk) begin
        if (!nrst) begin
            csSync_reg  <= SYNC_RESET_HIGH;
            sckSync_reg <= SYNC_RESET_LOW;
            siSync_reg  <= SYNC_RESET_LOW;
        end else begin
            csSync_reg  <= {csSync_reg[1:0], csN};
            sckSync_reg <= {sckSync_reg[1:0], sck};
            siSync_reg  <= {siSync_reg[1:0], si};
        end
    end

    assign link.sckRise  = sckSync_reg[1] && !sckSync_reg[2];
    assign link.sckFall  = !sckSync_reg[1] && sckSync_reg[2];
    assign link.csRise   = csSync_reg[1] && !csSync_reg[2];
    assign link.selected = !csSync_reg[1] && !csSync_reg[2];
    assign link.dataBit  = siSync_reg[2];

    assign rxByte   = {inShift_reg, link.dataBit};
    assign byteDone = link.selected && link.sckRise && (bitCnt_reg == 3'(BYTE_BITS - 1));
    assign addrFull = ADDR_W'({addrHi_reg, rxByte});

    // Input shifter, sampled on serial clock rise
    always_ff @(posedge clk) begin
        if (!nrst || !link.selected) begin
            bitCnt_reg  <= 3'h0;
            inShift_reg <= 7'h0;
        end else if (link.sckRise) begin
            bitCnt_reg  <= bitCnt_reg + 3'h1;
            inShift_reg <= rxByte[6:0];
        end
    end

    // Command decoder
    always_ff @(posedge clk) begin
        if (!nrst || !link.selected) begin
            state_reg    <= ST_OPCODE;
            isWrite_reg  <= 1'b0;
            latchSet_reg <= 1'b0;
            addrCnt_reg  <= 1'b0;
            addrHi_reg   <= 8'h0;
        end else begin
            unique case (state_reg)
                ST_OPCODE: if (byteDone) begin
                    unique case (rxByte)
                        OPC_READ: begin
                            state_reg   <= busy_reg ? ST_IGNORE : ST_ADDR;
                            isWrite_reg <= 1'b0;
                        end
                        OPC_WRITE: begin
                            state_reg   <= busy_reg ? ST_IGNORE : ST_ADDR;
                            isWrite_reg <= 1'b1;
                        end
                        OPC_STATUS_READ: state_reg <= ST_STATUS;
                        OPC_SET_LATCH, OPC_CLEAR_LATCH: begin
                            state_reg    <= busy_reg ? ST_IGNORE : ST_LATCH;
                            latchSet_reg <= (rxByte == OPC_SET_LATCH);
                        end
                        default: state_reg <= ST_IGNORE;
                    endcase
                end
                ST_ADDR: if (byteDone) begin
                    addrHi_reg  <= rxByte;
                    addrCnt_reg <= 1'b1;
                    if (addrCnt_reg) begin
                        state_reg <= isWrite_reg ? ST_WDATA : ST_RDATA;
                    end
                end
                // Any clock past the eighth bit spoils the latch command
                ST_LATCH: if (link.sckRise) state_reg <= ST_IGNORE;
                ST_RDATA, ST_WDATA, ST_STATUS, ST_IGNORE: state_reg <= state_reg;
            endcase
        end
    end

    // Page assembly: bytes land in the page buffer at a wrapping offset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pageMask_reg <= '0;
            pageOff_reg  <= '0;
            pageSel_reg  <= '0;
            gotData_reg  <= 1'b0;
        end else if (!busy_reg) begin
            if (state_reg == ST_ADDR && byteDone && addrCnt_reg && isWrite_reg) begin
                pageMask_reg <= '0;
                pageOff_reg  <= addrFull[OFF_W-1:0];
                pageSel_reg  <= addrFull[ADDR_W-1:OFF_W];
                gotData_reg  <= 1'b0;
            end else if (state_reg == ST_WDATA && byteDone) begin
                pageBuf_reg[pageOff_reg]  <= rxByte;
                pageMask_reg[pageOff_reg] <= 1'b1;
                pageOff_reg               <= pageOff_reg + 1'b1;
                gotData_reg               <= 1'b1;
            end
        end
    end

    // Commit only on a select rise at a byte boundary after at least one byte
    assign writeGo = link.csRise && state_reg == ST_WDATA && bitCnt_reg == 3'h0
                     && gotData_reg && latch_reg && !busy_reg
                     && !isProtected({pageSel_reg, {OFF_W{1'b0}}}, protect_reg);
    assign busyDone = busy_reg && (busyCnt_reg == CNT_W'(WRITE_CYCLES - 1));

    // Self-timed write cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy_reg    <= 1'b0;
            busyCnt_reg <= '0;
        end else if (writeGo) begin
            busy_reg    <= 1'b1;
            busyCnt_reg <= '0;
        end else if (busyDone) begin
            busy_reg    <= 1'b0;
        end else if (busy_reg) begin
            busyCnt_reg <= busyCnt_reg + 1'b1;
        end
    end

    // Whole page is erased and rewritten; untouched bytes take their old value
    always_ff @(posedge clk) begin
        if (busyDone) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                mem_reg[{pageSel_reg, OFF_W'(i)}] <= pageMask_reg[i]
                    ? pageBuf_reg[i] : mem_reg[{pageSel_reg, OFF_W'(i)}];
            end
        end
    end

    // Write enable latch
    always_ff @(posedge clk) begin
        if (!nrst) begin
            latch_reg <= 1'b0;
        end else if (busyDone) begin
            latch_reg <= 1'b0;
        end else if (link.csRise && state_reg == ST_LATCH) begin
            latch_reg <= latchSet_reg;
        end
    end

    // Protect bits have no writer here; they hold their strapped value
    always_ff @(posedge clk) begin
        if (!nrst) begin
            protect_reg   <= PROTECT_INIT;
            pinEnable_reg <= PIN_EN_INIT;
        end
    end

    always_comb begin
        status.protectPinEnable = pinEnable_reg;
        status.unused           = STATUS_UNUSED;
        status.protectHi        = protect_reg[1];
        status.protectLo        = protect_reg[0];
        status.latchFlag        = latch_reg;
        status.busyFlag         = busy_reg;
    end

    // Read prefetch into the two-entry buffer; a stalled shifter stops the fetch
    assign fetchValid = (state_reg == ST_RDATA) && link.selected && !busy_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            readPtr_reg <= '0;
        end else if (state_reg == ST_ADDR && byteDone && addrCnt_reg) begin
            readPtr_reg <= addrFull;
        end else if (fetchValid && fetchReady) begin
            readPtr_reg <= readPtr_reg + 1'b1;
        end
    end

    sem_buf2 #(
        .WIDTH    (BYTE_BITS)
    ) u_readBuf (
        .clk      (clk),
        .nrst     (nrst),
        .flush    (!link.selected),
        .inValid  (fetchValid),
        .inData   (mem_reg[readPtr_reg]),
        .inReady  (fetchReady),
        .outValid (popValid),
        .outData  (popData),
        .outReady (popReady)
    );

    assign outLoad  = link.selected && link.sckFall && outCnt_reg == 3'h0
                      && (state_reg == ST_RDATA || state_reg == ST_STATUS);
    assign popReady = outLoad && state_reg == ST_RDATA;
    assign loadByte = (state_reg == ST_STATUS) ? status : (popValid ? popData : 8'h0);

    // Output shifter, updated on serial clock fall
    always_ff @(posedge clk) begin
        if (!nrst || !link.selected) begin
            outCnt_reg   <= 3'h0;
            outShift_reg <= 7'h0;
            so           <= 1'b0;
            soOe         <= 1'b0;
        end else if (outLoad) begin
            so           <= loadByte[7];
            outShift_reg <= loadByte[6:0];
            outCnt_reg   <= 3'h1;
            soOe         <= 1'b1;
        end else if (link.sckFall && outCnt_reg != 3'h0) begin
            so           <= outShift_reg[6];
            outShift_reg <= {outShift_reg[5:0], 1'b0};
            outCnt_reg   <= outCnt_reg + 3'h1;
        end
    end

endmodule // sem_core

/* sem_pkg.sv */
// Operation
// - Select low, read opcode, two address bytes, then stored byte shifts out.
// - Continued clocking reads the next address after each byte sent.
// - Read pointer wraps from the top address to zero.
// - Chip select high ends a read and stops output.
// - Latch set only when select rises right after eight set-latch bits.
// - Extra clocks after set-latch opcode leave the latch untouched.
// - Each array write does its own erase of the whole page.
// - Write is opcode, address, then up to one page of data bytes.
// - Partial page writes rewrite the untouched bytes of the page too.
// - Write data past the page end wraps to the page start.
// - Select must rise right after a data byte, else write is dropped.
// - Select rise ending a valid write starts the timed write cycle.
// - No array data is returned while a write cycle runs.
// - Status read works at any time, also during a write cycle.
// - Write cycle completion clears the write enable latch.
// - Set and clear commands drive the latch; writes need it set.
// - Latch clears at reset and after each successful latch-clear or write.
// - Status: pin enable bit 7, protect bits 3 and 2, latch 1, busy 0.
// - Busy flag is one during a write cycle, zero otherwise.
// - Latch flag mirrors the latch; commands update it regardless of protection.
// - Protect bits flag protected blocks and are not changed by this logic.
// - Opcodes: read 03, write 02, status read 05.
// - Opcodes: set latch 06, clear latch 04.
// - All fields travel most significant bit first.
// - Input sampled on clock rise, output changes after clock fall.
package sem_pkg;

    localparam int          ADDR_W_DEF       = 16;
    localparam int          PAGE_BYTES_DEF   = 128;
    localparam int          BYTE_BITS        = 8;
    localparam int          ADDR_BYTES       = 2;
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          WRITE_TIME_US    = 100;
    localparam int          WRITE_CYCLES_DEF = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

    localparam logic [7:0]  OPC_READ         = 8'h03;
    localparam logic [7:0]  OPC_WRITE        = 8'h02;
    localparam logic [7:0]  OPC_STATUS_READ  = 8'h05;
    localparam logic [7:0]  OPC_SET_LATCH    = 8'h06;
    localparam logic [7:0]  OPC_CLEAR_LATCH  = 8'h04;

    localparam logic [2:0]  STATUS_UNUSED    = 3'h0;
    localparam logic [1:0]  PROTECT_NONE     = 2'h0;
    localparam logic [1:0]  PROTECT_QUARTER  = 2'h1;
    localparam logic [1:0]  PROTECT_HALF     = 2'h2;
    localparam logic [2:0]  SYNC_RESET_LOW   = 3'h0;
    localparam logic [2:0]  SYNC_RESET_HIGH  = 3'h7;

    // Bit order matches the status byte layout, bit 7 first
    typedef struct packed {
        logic       protectPinEnable;
        logic [2:0] unused;
        logic       protectHi;
        logic       protectLo;
        logic       latchFlag;
        logic       busyFlag;
    } sem_status_s;

    typedef struct packed {
        logic sckRise;
        logic sckFall;
        logic csRise;
        logic selected;
        logic dataBit;
    } sem_link_s;

    typedef enum {
        ST_OPCODE,
        ST_ADDR,
        ST_RDATA,
        ST_WDATA,
        ST_STATUS,
        ST_LATCH,
        ST_IGNORE
    } sem_state_e;

endpackage

/* sem_buf2.sv */
`timescale 1ns/1ps
module sem_buf2 import sem_pkg::*; #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             flush,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);

    logic [WIDTH-1:0] slot_reg [2];
    logic [1:0]       count_reg;
    logic             push;
    logic             pop;

    initial begin
        if (WIDTH < 1) $error("sem_buf2: WIDTH must be positive");
    end

    assign inReady  = (count_reg != 2'h2);
    assign outValid = (count_reg != 2'h0);
    assign outData  = slot_reg[0];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge clk) begin
        if (!nrst || flush) begin
            count_reg <= 2'h0;
        end else begin
            count_reg <= count_reg + 2'(push) - 2'(pop);
        end
    end

    // Entry 0 is always the head; a pop slides entry 1 down
    always_ff @(posedge clk) begin
        if (pop) begin
            slot_reg[0] <= (push && count_reg == 2'h1) ? inData : slot_reg[1];
        end else if (push && count_reg == 2'h0) begin
            slot_reg[0] <= inData;
        end
        // Second slot takes the word only when one is held and none leaves
        if (push && count_reg == 2'h1 && !pop) begin
            slot_reg[1] <= inData;
        end
    end

endmodule // sem_buf2

/* sem_core_properties.sv */
`timescale 1ns/1ps
module sem_core_properties import sem_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic soOe
);
    logic       sckPrev_reg;
    logic [9:0] riseCnt_reg;
    logic [3:0] sinceFall_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    always_ff @(posedge clk) begin
        sckPrev_reg <= sck;
    end
    // Counted at the pins, so windows below allow for the synchroniser
    always_ff @(posedge clk) begin
        if (!nrst || csN) begin
            riseCnt_reg <= 10'h0;
        end else if (sck && !sckPrev_reg && riseCnt_reg != 10'h3ff) begin
            riseCnt_reg <= riseCnt_reg + 10'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst || (sckPrev_reg && !sck)) begin
            sinceFall_reg <= 4'h0;
        end else if (sinceFall_reg != 4'hf) begin
            sinceFall_reg <= sinceFall_reg + 4'h1;
        end
    end

    property p_oe_idle; csN [*6] |-> !soOe; endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("output driven while deselected");
    property p_oe_release; $rose(csN) |-> ##[1:6] !soOe; endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("output not released after deselect");
    property p_oe_select; $rose(soOe) |-> !csN && !$past(csN, 4); endproperty
    a_oe_select: assert property (p_oe_select)
        else $error("output enabled without a frame");
    property p_oe_count;
        $rose(soOe) |-> riseCnt_reg inside {[10'h8:10'h9], [10'h18:10'h19]};
    endproperty
    a_oe_count: assert property (p_oe_count)
        else $error("output started after wrong bit count");
    property p_oe_fall; $rose(soOe) |-> sinceFall_reg inside {[4'h1:4'h8]}; endproperty
    a_oe_fall: assert property (p_oe_fall)
        else $error("output started away from a clock fall");
    property p_so_fall;
        soOe && $past(soOe) && $changed(so) |-> sinceFall_reg inside {[4'h1:4'h8]};
    endproperty
    a_so_fall: assert property (p_so_fall)
        else $error("output bit changed away from a clock fall");
    property p_oe_hold; (!csN) [*5] ##0 soOe |=> soOe; endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("output dropped inside a frame");
    property p_reset_quiet; $rose(nrst) |-> !soOe [*3]; endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("output driven right after reset");
endmodule // sem_core_properties

bind sem_core sem_core_properties u_props (
    .clk(clk), .nrst(nrst), .csN(csN), .sck(sck), .si(si), .so(so), .soOe(soOe)
);

/* sem_host.sv */
`timescale 1ns/1ps
module sem_host import sem_pkg::*; (
    input  wire logic       clk,
    output logic            csN,
    output logic            sck,
    output logic            si,
    input  wire logic       so,
    input  wire logic       soOe,
    output logic            rxValid,
    output logic [7:0]      rxByte,
    output logic            oeSeen
);
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        rxValid = 1'b0;
        rxByte = 8'h00;
        oeSeen = 1'b0;
    end

    // Output taken late in the high phase to ride out the pin synchroniser
    task automatic bitx(input logic b, output logic s);
        si <= b;
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        repeat (4) @(posedge clk);
        s = so;
        oeSeen = oeSeen | soOe;
        sck <= 1'b0;
    endtask

    task automatic frame(input logic [7:0] tx[$], input int nRx, input int extra);
        logic [7:0] r;
        logic       s;
        oeSeen = 1'b0;
        csN <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (tx[i]) begin
            for (int j = 7; j >= 0; j--) begin
                bitx(tx[i][j], s);
            end
        end
        for (int i = 0; i < nRx; i++) begin
            for (int j = 7; j >= 0; j--) begin
                bitx(1'($urandom), s);
                r[j] = s;
            end
            rxByte <= r;
            rxValid <= oeSeen;
            @(posedge clk);
            rxValid <= 1'b0;
        end
        for (int i = 0; i < extra; i++) begin
            bitx(1'($urandom), s);
        end
        repeat (4) @(posedge clk);
        csN <= 1'b1;
        si <= ~si;
        repeat (8) @(posedge clk);
    endtask
endmodule // sem_host

/* sem_core_tb.sv */
`timescale 1ns/1ps
module sem_core_tb import sem_pkg::*;;
    localparam int AW = 10;
    localparam int WC = 2000;
    localparam int DEPTH = 1 << AW;
    localparam int PM = PAGE_BYTES_DEF - 1;

    logic       clk;
    logic       nrst;
    logic       csN;
    logic       sck;
    logic       si;
    logic       so;
    logic       soOe;
    logic       rxValid;
    logic [7:0] rxByte;
    logic       oeSeen;
    logic [7:0] mem [DEPTH];
    logic [7:0] expQ[$];
    logic [7:0] tx[$];
    int         fails;
    int         comparisons;

    sem_host HOST (.clk(clk), .csN(csN), .sck(sck), .si(si), .so(so), .soOe(soOe),
                   .rxValid(rxValid), .rxByte(rxByte), .oeSeen(oeSeen));
    sem_core #(.ADDR_W(AW), .WRITE_CYCLES(WC)) DUT (.clk(clk), .nrst(nrst), .csN(csN),
                   .sck(sck), .si(si), .so(so), .soOe(soOe));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH time=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmd(input logic [7:0] opc, input int extra);
        tx = {opc};
        HOST.frame(tx, 0, extra);
    endtask

    task automatic status(input logic [7:0] e);
        expQ.push_back(e);
        expQ.push_back(e);
        tx = {OPC_STATUS_READ};
        HOST.frame(tx, 2, 0);
    endtask

    task automatic wr(input int a, input int n, input bit commit, input int extra);
        logic [7:0] d;
        tx = {OPC_WRITE, 8'(a >> 8), 8'(a)};
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            tx.push_back(d);
            if (commit) begin
                mem[(a & ~PM) | ((a + i) & PM)] = d;
            end
        end
        HOST.frame(tx, 0, extra);
    endtask

    task automatic rd(input int a, input int n, input bit want);
        tx = {OPC_READ, 8'(a >> 8), 8'(a)};
        for (int i = 0; i < n; i++) begin
            if (want) begin
                expQ.push_back(mem[(a + i) % DEPTH]);
            end
        end
        HOST.frame(tx, n, 0);
    endtask

    always @(posedge clk) begin
        if (rxValid === 1'b1) begin
            if (expQ.size() == 0) begin
                fails++;
                comparisons++;
                $display("MISMATCH time=%0t seen=%h expected=%h", $time, rxByte, 8'h00);
            end else begin
                check(rxByte, expQ.pop_front());
            end
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        end_of_test();
    end

    initial begin
        nrst = 1'b0;
        fails = 0;
        comparisons = 0;
        void'($urandom(32'h5ae1729e));
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        status(8'h00);
        cmd(OPC_SET_LATCH, 0);
        status(8'h02);
        cmd(OPC_CLEAR_LATCH, 0);
        status(8'h00);
        cmd(OPC_SET_LATCH, 3);
        status(8'h00);
        cmd(OPC_SET_LATCH, 0);
        wr(12'h380, PAGE_BYTES_DEF, 1'b1, 0);
        repeat (WC + 20) @(posedge clk);
        cmd(OPC_SET_LATCH, 0);
        wr(0, 2, 1'b1, 0);
        status(8'h03);
        rd(0, 1, 1'b0);
        check({7'h0, oeSeen}, 8'h00);
        repeat (WC + 20) @(posedge clk);
        status(8'h00);
        cmd(OPC_SET_LATCH, 0);
        wr(12'h3fe, 4, 1'b1, 0);
        repeat (WC + 20) @(posedge clk);
        rd(12'h380, PAGE_BYTES_DEF + 2, 1'b1);
        cmd(OPC_SET_LATCH, 0);
        wr(0, 1, 1'b0, 3);
        status(8'h02);
        cmd(OPC_CLEAR_LATCH, 0);
        wr(1, 1, 1'b0, 0);
        status(8'h00);
        tx = {OPC_SET_LATCH, OPC_WRITE, 8'h00, 8'h00, 8'h5a};
        HOST.frame(tx, 0, 0);
        status(8'h00);
        rd(0, 2, 1'b1);
        check(8'(expQ.size()), 8'h00);
        end_of_test();
    end
endmodule // sem_core_tb
